// File: pfms_pin_function_mode_select.sv
// What this block does
// - Bus pin function fixed at reset only
// - Serial pins reconfigurable by software anytime
// - Shared pins keep flag and interrupt
// - Enabled interrupt fires from external or own drive
// - Boot straps sampled at reset, then flags
// - Control field picks serial or irq/flag use
// - Memory mode from captured strap, never changes
// - Full mode byte DMA, host mode host DMA
// - Each shared memory pin carries one signal
// - Edge, level and configurable interrupt detection
// - Strap zero full mode, one host mode
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module pfms_pin_function_mode_select
    import pfms_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // General flag pins, low four double as boot straps
    input wire logic [7:0] i_gp_flag_in,
    output logic [7:0] o_gp_flag_out,
    output logic [7:0] o_gp_flag_oe,
    // Second serial port pins
    input wire logic [3:0] i_sp_pin_in,
    output logic [3:0] o_sp_pin_out,
    output logic [3:0] o_sp_pin_oe,
    // Second serial port core side
    input wire logic [3:0] i_sport_out,
    input wire logic [3:0] i_sport_oe,
    output logic [3:0] o_sport_in,
    // Shared memory interface pins
    input wire logic [15:0] i_mem_pin_in,
    output logic [15:0] o_mem_pin_out,
    output logic [15:0] o_mem_pin_oe,
    // Full memory mode bus core side
    input wire logic [15:0] i_full_bus_out,
    input wire logic [15:0] i_full_bus_oe,
    output logic [15:0] o_full_bus_in,
    // Host port core side
    input wire logic [15:0] i_host_port_out,
    input wire logic [15:0] i_host_port_oe,
    output logic [15:0] o_host_port_in,
    // Mode and interrupt outputs
    output logic o_byte_dma_en,
    output logic o_host_internal_dma_en,
    output logic o_boot_done,
    output logic [3:0] o_boot_mode,
    output logic o_irq
);

    localparam int PIN_W = PFMS_FLAG_W + PFMS_SP_PIN_W + PFMS_MEM_PIN_W;

    pfms_state_type state_reg;
    pfms_state_type state_next;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic [7:0] flag_sync;
    logic [3:0] sp_sync;
    logic [15:0] mem_sync;
    logic [3:0] strap_reg;
    logic [2:0] sys_ctrl_reg;
    logic [7:0] flag_dir_reg;
    logic [8:0] flag_out_reg;
    logic [5:0] irq_stat_reg;
    logic [5:0] irq_stat_next;
    logic [5:0] interrupt_enable_mask_reg;
    logic [5:0] irq_prev_n_reg;
    logic [5:0] irq_lvl_n;
    logic [5:0] irq_edge_mode;
    logic [5:0] irq_hit;
    logic [5:0] irq_clear;
    logic [7:0] flag_level;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic sp_alt;
    logic host_mode;
    logic apb_setup;
    logic apb_access;
    logic apb_wr;
    logic addr_hit;
    logic [3:0] sp_out_reg;
    logic [3:0] sp_oe_reg;
    logic [3:0] sport_in_reg;
    logic [15:0] mem_out_reg;
    logic [15:0] mem_oe_reg;
    logic [15:0] full_in_reg;
    logic [15:0] host_in_reg;
    logic irq_reg;

    // Interrupt detector: edge or active-low level
    function automatic logic irq_detect(input logic lvl_n,
                                        input logic prev_n,
                                        input logic edge_mode);
        irq_detect = edge_mode ? (prev_n & ~lvl_n) : ~lvl_n;
    endfunction : irq_detect

    // Register map decode
    function automatic logic addr_mapped(input logic [7:0] addr);
        case (addr)
            PFMS_SYS_CTRL_OFS,
            PFMS_FLAG_DIR_OFS,
            PFMS_FLAG_OUT_OFS,
            PFMS_FLAG_IN_OFS,
            PFMS_IRQ_STAT_OFS,
            PFMS_IRQ_MASK_OFS,
            PFMS_MODE_STAT_OFS: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    // Pin synchroniser, unreset so straps are tracked during reset
    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en) begin
            pin_meta <= {i_mem_pin_in, i_sp_pin_in, i_gp_flag_in};
            pin_sync <= pin_meta;
        end
    end

    assign flag_sync = pin_sync[7:0];
    assign sp_sync = pin_sync[11:8];
    assign mem_sync = pin_sync[27:12];

    // Boot sequencing
    always_comb begin
        case (state_reg)
            PFMS_ST_CAPTURE: state_next = PFMS_ST_RUN;
            PFMS_ST_RUN: state_next = PFMS_ST_RUN;
            default: state_next = PFMS_ST_CAPTURE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= PFMS_ST_CAPTURE;
        end else if (i_clk_en) begin
            state_reg <= state_next;
        end
    end

    // Strap capture at first edge after reset release
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_reg <= PFMS_STRAP_RST;
        end else if (i_clk_en && state_reg == PFMS_ST_CAPTURE) begin
            strap_reg <= flag_sync[3:0];
        end
    end

    assign host_mode = (strap_reg[PFMS_STRAP_MEM_MODE_BIT]
                        == PFMS_MEM_MODE_HOST);
    assign sp_alt = sys_ctrl_reg[PFMS_CTRL_SP_ALT_BIT];

    // APB decode
    assign apb_setup = i_psel & ~i_penable;
    assign apb_access = i_psel & i_penable & i_clk_en;
    assign apb_wr = apb_access & i_pwrite & addr_hit;
    assign addr_hit = addr_mapped(i_paddr);
    assign o_pready = i_clk_en;
    assign o_prdata = prdata_reg;
    assign o_pslverr = pslverr_reg & i_psel & i_penable;

    // System control
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_ctrl_reg <= PFMS_SYS_CTRL_RST;
        end else if (apb_wr && i_paddr == PFMS_SYS_CTRL_OFS) begin
            sys_ctrl_reg <= i_pwdata[2:0];
        end
    end

    // Flag direction and output data
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_dir_reg <= PFMS_FLAG_DIR_RST;
            flag_out_reg <= PFMS_FLAG_OUT_RST;
        end else if (apb_wr) begin
            if (i_paddr == PFMS_FLAG_DIR_OFS) begin
                flag_dir_reg <= i_pwdata[7:0];
            end
            if (i_paddr == PFMS_FLAG_OUT_OFS) begin
                flag_out_reg <= i_pwdata[8:0];
            end
        end
    end

    // Flag pins, straps undriven until capture done
    always_comb begin
        o_gp_flag_out = flag_out_reg[7:0];
        o_gp_flag_oe = flag_dir_reg;
        if (state_reg != PFMS_ST_RUN) begin
            o_gp_flag_oe = 8'h00;
        end
    end

    // Driven pins read back own level
    assign flag_level = (o_gp_flag_oe & flag_out_reg[7:0])
                        | (~o_gp_flag_oe & flag_sync);

    // Interrupt request levels, active low
    always_comb begin
        irq_lvl_n = 6'h3f;
        irq_lvl_n[PFMS_IRQ_EDGE] = flag_level[PFMS_FLAG_EDGE_IRQ];
        irq_lvl_n[PFMS_IRQ_LVL_0] = flag_level[PFMS_FLAG_LVL_IRQ_0];
        irq_lvl_n[PFMS_IRQ_LVL_1] = flag_level[PFMS_FLAG_LVL_IRQ_1];
        irq_lvl_n[PFMS_IRQ_CFG] = flag_level[PFMS_FLAG_CFG_IRQ];
        if (sp_alt) begin
            irq_lvl_n[PFMS_IRQ_SP_0] = sp_sync[PFMS_SP_IRQ0_PIN];
            irq_lvl_n[PFMS_IRQ_SP_1] = sp_sync[PFMS_SP_IRQ1_PIN];
        end
    end

    // Detection mode per source
    always_comb begin
        irq_edge_mode = 6'h00;
        irq_edge_mode[PFMS_IRQ_EDGE] = 1'b1;
        irq_edge_mode[PFMS_IRQ_CFG] = sys_ctrl_reg[PFMS_CTRL_CFG_EDGE_BIT];
        irq_edge_mode[PFMS_IRQ_SP_0] = sys_ctrl_reg[PFMS_CTRL_SP_EDGE_BIT];
        irq_edge_mode[PFMS_IRQ_SP_1] = sys_ctrl_reg[PFMS_CTRL_SP_EDGE_BIT];
    end

    always_comb begin
        for (int i = 0; i < PFMS_IRQ_W; i++) begin
            irq_hit[i] = irq_detect(irq_lvl_n[i], irq_prev_n_reg[i],
                                    irq_edge_mode[i]);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_prev_n_reg <= 6'h3f;
        end else if (i_clk_en) begin
            irq_prev_n_reg <= irq_lvl_n;
        end
    end

    // Sticky status, write one to clear, set wins
    assign irq_clear = (apb_wr && i_paddr == PFMS_IRQ_STAT_OFS)
                       ? i_pwdata[5:0] : 6'h00;
    assign irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_hit;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_stat_reg <= PFMS_IRQ_STAT_RST;
        end else if (i_clk_en && state_reg == PFMS_ST_RUN) begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Interrupt enable mask
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            interrupt_enable_mask_reg <= PFMS_IRQ_MASK_RST;
        end else if (apb_wr && i_paddr == PFMS_IRQ_MASK_OFS) begin
            interrupt_enable_mask_reg <= i_pwdata[5:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_reg <= 1'b0;
        end else if (i_clk_en) begin
            irq_reg <= |(irq_stat_next & interrupt_enable_mask_reg);
        end
    end

    assign o_irq = irq_reg;

    // Read data, loaded in setup cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (i_clk_en && apb_setup) begin
            pslverr_reg <= ~addr_hit;
            prdata_reg <= 32'h0000_0000;
            case (i_paddr)
                PFMS_SYS_CTRL_OFS: prdata_reg[2:0] <= sys_ctrl_reg;
                PFMS_FLAG_DIR_OFS: prdata_reg[7:0] <= flag_dir_reg;
                PFMS_FLAG_OUT_OFS: prdata_reg[8:0] <= flag_out_reg;
                PFMS_FLAG_IN_OFS: begin
                    prdata_reg[7:0] <= flag_level;
                    prdata_reg[PFMS_SP_FLAG_BIT] <=
                        sp_alt & sp_sync[PFMS_SP_FLAG_IN_PIN];
                end
                PFMS_IRQ_STAT_OFS: prdata_reg[5:0] <= irq_stat_reg;
                PFMS_IRQ_MASK_OFS: begin
                    prdata_reg[5:0] <= interrupt_enable_mask_reg;
                end
                PFMS_MODE_STAT_OFS: begin
                    prdata_reg[3:0] <= strap_reg;
                    prdata_reg[PFMS_CAPTURED_BIT] <=
                        (state_reg == PFMS_ST_RUN);
                end
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Second serial port pin mux, switchable at run time
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sp_out_reg <= 4'h0;
            sp_oe_reg <= 4'h0;
            sport_in_reg <= 4'h0;
        end else if (i_clk_en) begin
            if (sp_alt) begin
                sp_out_reg <= 4'h0;
                sp_out_reg[PFMS_SP_FLAG_OUT_PIN] <=
                    flag_out_reg[PFMS_SP_FLAG_BIT];
                sp_oe_reg <= 4'h0;
                sp_oe_reg[PFMS_SP_FLAG_OUT_PIN] <= 1'b1;
                sport_in_reg <= 4'h0;
            end else begin
                sp_out_reg <= i_sport_out;
                sp_oe_reg <= i_sport_oe;
                sport_in_reg <= sp_sync;
            end
        end
    end

    assign o_sp_pin_out = sp_out_reg;
    assign o_sp_pin_oe = sp_oe_reg;
    assign o_sport_in = sport_in_reg;

    // Shared memory pin mux from held mode
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mem_out_reg <= 16'h0000;
            mem_oe_reg <= 16'h0000;
            full_in_reg <= 16'h0000;
            host_in_reg <= 16'h0000;
        end else if (i_clk_en) begin
            if (state_reg != PFMS_ST_RUN) begin
                mem_out_reg <= 16'h0000;
                mem_oe_reg <= 16'h0000;
                full_in_reg <= 16'h0000;
                host_in_reg <= 16'h0000;
            end else if (host_mode) begin
                mem_out_reg <= i_host_port_out;
                mem_oe_reg <= i_host_port_oe;
                full_in_reg <= 16'h0000;
                host_in_reg <= mem_sync;
            end else begin
                mem_out_reg <= i_full_bus_out;
                mem_oe_reg <= i_full_bus_oe;
                full_in_reg <= mem_sync;
                host_in_reg <= 16'h0000;
            end
        end
    end

    assign o_mem_pin_out = mem_out_reg;
    assign o_mem_pin_oe = mem_oe_reg;
    assign o_full_bus_in = full_in_reg;
    assign o_host_port_in = host_in_reg;

    // Mode enables follow captured strap, gated by boot done
    assign o_byte_dma_en = (state_reg == PFMS_ST_RUN) & ~host_mode;
    assign o_host_internal_dma_en = (state_reg == PFMS_ST_RUN)
                                    & host_mode;
    assign o_boot_done = (state_reg == PFMS_ST_RUN);
    assign o_boot_mode = strap_reg;

endmodule : pfms_pin_function_mode_select

// File: pfms_pkg.sv
package pfms_pkg;

    // Widths
    localparam int PFMS_ADDR_W = 8;
    localparam int PFMS_DATA_W = 32;
    localparam int PFMS_FLAG_W = 8;
    localparam int PFMS_STRAP_W = 4;
    localparam int PFMS_MEM_PIN_W = 16;
    localparam int PFMS_SP_PIN_W = 4;
    localparam int PFMS_IRQ_W = 6;
    localparam int PFMS_CTRL_W = 3;

    // Register offsets
    localparam logic [7:0] PFMS_SYS_CTRL_OFS = 8'h00;
    localparam logic [7:0] PFMS_FLAG_DIR_OFS = 8'h04;
    localparam logic [7:0] PFMS_FLAG_OUT_OFS = 8'h08;
    localparam logic [7:0] PFMS_FLAG_IN_OFS = 8'h0c;
    localparam logic [7:0] PFMS_IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] PFMS_IRQ_MASK_OFS = 8'h14;
    localparam logic [7:0] PFMS_MODE_STAT_OFS = 8'h18;

    // System control fields
    localparam int PFMS_CTRL_SP_ALT_BIT = 0;
    localparam int PFMS_CTRL_CFG_EDGE_BIT = 1;
    localparam int PFMS_CTRL_SP_EDGE_BIT = 2;

    // Flag and mode status register fields
    localparam int PFMS_SP_FLAG_BIT = 8;
    localparam int PFMS_CAPTURED_BIT = 4;

    // Strap fields
    localparam int PFMS_STRAP_MEM_MODE_BIT = 2;
    localparam logic PFMS_MEM_MODE_FULL = 1'b0;
    localparam logic PFMS_MEM_MODE_HOST = 1'b1;

    // Flag pin shared with each of the four flag interrupts
    localparam int PFMS_FLAG_EDGE_IRQ = 4;
    localparam int PFMS_FLAG_LVL_IRQ_0 = 5;
    localparam int PFMS_FLAG_LVL_IRQ_1 = 6;
    localparam int PFMS_FLAG_CFG_IRQ = 7;

    // Second serial port pin roles in alternate use
    localparam int PFMS_SP_IRQ0_PIN = 0;
    localparam int PFMS_SP_IRQ1_PIN = 1;
    localparam int PFMS_SP_FLAG_IN_PIN = 2;
    localparam int PFMS_SP_FLAG_OUT_PIN = 3;

    // Interrupt status bits
    localparam int PFMS_IRQ_EDGE = 0;
    localparam int PFMS_IRQ_LVL_0 = 1;
    localparam int PFMS_IRQ_LVL_1 = 2;
    localparam int PFMS_IRQ_CFG = 3;
    localparam int PFMS_IRQ_SP_0 = 4;
    localparam int PFMS_IRQ_SP_1 = 5;

    // Reset values
    localparam logic [2:0] PFMS_SYS_CTRL_RST = 3'h0;
    localparam logic [7:0] PFMS_FLAG_DIR_RST = 8'h00;
    localparam logic [8:0] PFMS_FLAG_OUT_RST = 9'h000;
    localparam logic [5:0] PFMS_IRQ_STAT_RST = 6'h00;
    localparam logic [5:0] PFMS_IRQ_MASK_RST = 6'h00;
    localparam logic [3:0] PFMS_STRAP_RST = 4'h0;

    // Boot sequencing
    typedef enum logic [1:0] {
        PFMS_ST_CAPTURE = 2'b01,
        PFMS_ST_RUN = 2'b10
    } pfms_state_type;

endpackage : pfms_pkg

// File: pfms_properties.sv
`timescale 1ns/1ps
module pfms_checker
    import pfms_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // Core side inputs
    input wire logic [3:0] i_sport_oe,
    input wire logic [15:0] i_full_bus_out,
    input wire logic [15:0] i_host_port_out,
    // Design outputs
    input wire logic [7:0] o_gp_flag_oe,
    input wire logic [3:0] o_sp_pin_oe,
    input wire logic [3:0] o_sport_in,
    input wire logic [15:0] o_mem_pin_out,
    input wire logic [15:0] o_mem_pin_oe,
    input wire logic [15:0] o_full_bus_in,
    input wire logic [15:0] o_host_port_in,
    input wire logic o_byte_dma_en,
    input wire logic o_host_internal_dma_en,
    input wire logic o_boot_done,
    input wire logic [3:0] o_boot_mode,
    input wire logic o_irq
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_boot_hold;
        o_boot_done && $past(o_boot_done) |-> $stable(o_boot_mode);
    endproperty
    a_boot_hold: assert property (p_boot_hold)
        else $error("boot mode changed while running");
    property p_boot_rise;
        i_rst_n && i_clk_en && !o_boot_done |=> o_boot_done;
    endproperty
    a_boot_rise: assert property (p_boot_rise)
        else $error("straps not captured at first enabled edge");
    property p_mode_map;
        o_boot_done && $past(o_boot_done)
            |-> o_host_internal_dma_en == o_boot_mode[2];
    endproperty
    a_mode_map: assert property (p_mode_map)
        else $error("host mode does not follow strap");
    property p_mode_excl;
        $past(o_boot_done) |-> o_byte_dma_en != o_host_internal_dma_en;
    endproperty
    a_mode_excl: assert property (p_mode_excl)
        else $error("dma modes not exclusive");
    property p_mem_idle;
        !o_boot_done |-> o_mem_pin_oe == 16'h0000;
    endproperty
    a_mem_idle: assert property (p_mem_idle)
        else $error("memory pins driven before boot");
    property p_mem_mux;
        o_boot_done |=> o_mem_pin_out == (o_boot_mode[2] ?
            $past(i_host_port_out) : $past(i_full_bus_out));
    endproperty
    a_mem_mux: assert property (p_mem_mux)
        else $error("memory pin carries wrong signal");
    property p_other_in;
        o_boot_done && $past(o_boot_done) |->
            (o_boot_mode[2] ? o_full_bus_in : o_host_port_in) == 16'h0000;
    endproperty
    a_other_in: assert property (p_other_in)
        else $error("inactive bus side sees pins");
    property p_flag_idle;
        !o_boot_done |-> o_gp_flag_oe == 8'h00;
    endproperty
    a_flag_idle: assert property (p_flag_idle)
        else $error("flag pins driven during boot");
    property p_sp_oe;
        o_boot_done |-> o_sp_pin_oe == $past(i_sport_oe)
            || o_sp_pin_oe == 4'h8;
    endproperty
    a_sp_oe: assert property (p_sp_oe)
        else $error("serial pin enable wrong");
    property p_sp_alt_in;
        o_sp_pin_oe == 4'h8 |-> o_sport_in == 4'h0;
    endproperty
    a_sp_alt_in: assert property (p_sp_alt_in)
        else $error("serial core sees pins in alternate use");

    c_host: cover property (o_host_internal_dma_en);
    c_irq: cover property (o_irq);
    c_sp_alt: cover property (o_sp_pin_oe == 4'h8);
endmodule : pfms_checker

bind pfms_pin_function_mode_select pfms_checker u_pfms_checker (
    .i_sys_clk, .i_rst_n, .i_clk_en, .i_sport_oe, .i_full_bus_out,
    .i_host_port_out, .o_gp_flag_oe, .o_sp_pin_oe, .o_sport_in,
    .o_mem_pin_out, .o_mem_pin_oe, .o_full_bus_in, .o_host_port_in,
    .o_byte_dma_en, .o_host_internal_dma_en, .o_boot_done, .o_boot_mode,
    .o_irq
);

// File: pfms_ext_model.sv
`timescale 1ns/1ps
module pfms_ext_model (
    // Clock
    input wire logic i_sys_clk,
    // Outside drive
    input wire logic [7:0] i_ext_flag,
    input wire logic [7:0] i_ext_flag_en,
    input wire logic [3:0] i_ext_sp,
    input wire logic [15:0] i_ext_mem,
    input wire logic [15:0] i_ext_mem_en,
    // Device drive
    input wire logic [7:0] i_flag_out,
    input wire logic [7:0] i_flag_oe,
    input wire logic [3:0] i_sp_out,
    input wire logic [3:0] i_sp_oe,
    input wire logic [15:0] i_mem_out,
    input wire logic [15:0] i_mem_oe,
    // Resolved pin levels
    output logic [7:0] o_flag_pin,
    output logic [3:0] o_sp_pin,
    output logic [15:0] o_mem_pin
);
    logic [15:0] float_reg = 16'h5a5a;

    // Floating bus lines toggle every cycle
    always @(posedge i_sys_clk) begin
        float_reg <= ~float_reg;
    end

    // Pulled-up flags, own drive wins over outside
    assign o_flag_pin = (i_flag_oe & i_flag_out)
        | (~i_flag_oe & (i_ext_flag | ~i_ext_flag_en));
    assign o_sp_pin = (i_sp_oe & i_sp_out) | (~i_sp_oe & i_ext_sp);
    assign o_mem_pin = (i_mem_oe & i_mem_out) | (~i_mem_oe
        & ((i_ext_mem_en & i_ext_mem) | (~i_ext_mem_en & float_reg)));
endmodule : pfms_ext_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
    import pfms_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdq;
    logic [3:0] sport_out = 4'h7, sport_oe = 4'h7, ext_sp = 4'ha;
    logic [15:0] full_out = 16'h1234, full_oe = 16'h00ff;
    logic [15:0] host_out = 16'h9abc, host_oe = 16'hff00;
    logic [7:0] ext_flag = 8'hf3, ext_en = 8'h0f;
    logic [15:0] ext_mem = 16'ha5c3, ext_mem_en = 16'hff00;
    logic pready, pslverr, last_err, byte_dma, hdma, bdone, irq;
    logic [7:0] flag_out, flag_oe, flag_pin;
    logic [3:0] sp_out, sp_oe, sport_in, sp_pin, bmode;
    logic [15:0] mem_out, mem_oe, mem_pin, full_in, host_in;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #20 clk = ~clk;

    pfms_pin_function_mode_select u_pfms_pin_function_mode_select (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_gp_flag_in(flag_pin),
        .o_gp_flag_out(flag_out), .o_gp_flag_oe(flag_oe),
        .i_sp_pin_in(sp_pin), .o_sp_pin_out(sp_out), .o_sp_pin_oe(sp_oe),
        .i_sport_out(sport_out), .i_sport_oe(sport_oe),
        .o_sport_in(sport_in), .i_mem_pin_in(mem_pin),
        .o_mem_pin_out(mem_out), .o_mem_pin_oe(mem_oe),
        .i_full_bus_out(full_out), .i_full_bus_oe(full_oe),
        .o_full_bus_in(full_in), .i_host_port_out(host_out),
        .i_host_port_oe(host_oe), .o_host_port_in(host_in),
        .o_byte_dma_en(byte_dma), .o_host_internal_dma_en(hdma),
        .o_boot_done(bdone), .o_boot_mode(bmode), .o_irq(irq));

    pfms_ext_model u_pfms_ext_model (
        .i_sys_clk(clk), .i_ext_flag(ext_flag), .i_ext_flag_en(ext_en),
        .i_ext_sp(ext_sp), .i_ext_mem(ext_mem), .i_ext_mem_en(ext_mem_en),
        .i_flag_out(flag_out), .i_flag_oe(flag_oe), .i_sp_out(sp_out),
        .i_sp_oe(sp_oe), .i_mem_out(mem_out), .i_mem_oe(mem_oe),
        .o_flag_pin(flag_pin), .o_sp_pin(sp_pin), .o_mem_pin(mem_pin));

    task automatic print_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                n_mismatch++;
                print_verdict();
            end
            @(posedge clk);
        end
        rdq = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdq);
    endtask : rd

    task automatic settle;
        repeat (4) @(posedge clk);
    endtask : settle

    task automatic boot(input logic [3:0] s);
        rst_n <= 1'b0;
        ext_flag <= {4'hf, s};
        ext_en <= 8'h0f;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        settle();
    endtask : boot

    initial begin
        boot(4'h3);
        chk("boot_mode", 32'h3, bmode);
        chk("boot_done", 32'h1, bdone);
        chk("byte_dma_en", 32'h1, byte_dma);
        chk("host_dma_en", 32'h0, hdma);
        ext_flag <= 8'hf4;
        settle();
        chk("boot_mode_held", 32'h3, bmode);
        rd("mode_stat", PFMS_MODE_STAT_OFS, 32'h13);
        chk("mem_out", full_out, mem_out);
        chk("mem_oe", full_oe, mem_oe);
        chk("full_in_hi", 16'ha500, full_in & 16'hff00);
        chk("sp_out", sport_out, sp_out);
        chk("sp_oe", sport_oe, sp_oe);
        chk("sport_in", 4'hf, sport_in);
        ext_sp <= 4'he;
        wr(PFMS_SYS_CTRL_OFS, 32'h1);
        wr(PFMS_FLAG_OUT_OFS, 32'h1a5);
        settle();
        chk("flag_out", 8'ha5, flag_out);
        chk("sp_oe_alt", 4'h8, sp_oe);
        chk("sp_flag_out", 4'h8, sp_out & 4'h8);
        chk("sport_in_alt", 4'h0, sport_in);
        rd("flag_in", PFMS_FLAG_IN_OFS, 32'h1f4);
        rd("sp_irq", PFMS_IRQ_STAT_OFS, 32'h10);
        chk("irq_masked", 1'b0, irq);
        wr(PFMS_IRQ_MASK_OFS, 32'h3f);
        settle();
        chk("irq", 1'b1, irq);
        wr(PFMS_SYS_CTRL_OFS, 32'h5);
        wr(PFMS_IRQ_STAT_OFS, 32'h10);
        rd("sp_edge", PFMS_IRQ_STAT_OFS, 32'h0);
        wr(PFMS_SYS_CTRL_OFS, 32'h0);
        settle();
        wr(PFMS_IRQ_STAT_OFS, 32'h10);
        rd("stat_clr", PFMS_IRQ_STAT_OFS, 32'h0);
        chk("sp_oe_back", sport_oe, sp_oe);
        chk("irq_clr", 1'b0, irq);
        ext_en <= 8'h1f;
        ext_flag <= 8'he4;
        settle();
        rd("edge_set", PFMS_IRQ_STAT_OFS, 32'h1);
        wr(PFMS_IRQ_STAT_OFS, 32'h1);
        rd("edge_clr", PFMS_IRQ_STAT_OFS, 32'h0);
        ext_en <= 8'h3f;
        ext_flag <= 8'hc4;
        settle();
        wr(PFMS_IRQ_STAT_OFS, 32'h2);
        rd("lvl_stay", PFMS_IRQ_STAT_OFS, 32'h2);
        ext_en <= 8'h0f;
        settle();
        wr(PFMS_IRQ_STAT_OFS, 32'h2);
        rd("lvl_clr", PFMS_IRQ_STAT_OFS, 32'h0);
        wr(PFMS_FLAG_OUT_OFS, 32'h0);
        wr(PFMS_FLAG_DIR_OFS, 32'h40);
        settle();
        chk("flag_oe", 8'h40, flag_oe);
        rd("own_irq", PFMS_IRQ_STAT_OFS, 32'h4);
        rd("own_flag", PFMS_FLAG_IN_OFS, 32'hb4);
        wr(PFMS_FLAG_DIR_OFS, 32'h0);
        settle();
        wr(PFMS_IRQ_STAT_OFS, 32'h4);
        wr(PFMS_SYS_CTRL_OFS, 32'h2);
        ext_en <= 8'h8f;
        ext_flag <= 8'h74;
        settle();
        rd("cfg_set", PFMS_IRQ_STAT_OFS, 32'h8);
        wr(PFMS_IRQ_STAT_OFS, 32'h8);
        rd("cfg_edge", PFMS_IRQ_STAT_OFS, 32'h0);
        wr(PFMS_SYS_CTRL_OFS, 32'h0);
        settle();
        wr(PFMS_IRQ_STAT_OFS, 32'h8);
        rd("cfg_lvl", PFMS_IRQ_STAT_OFS, 32'h8);
        rd("unmapped", 8'h1c, 32'h0);
        chk("pslverr", 1'b1, last_err);
        ext_mem_en <= 16'h00ff;
        boot(4'h4);
        chk("boot_mode_h", 32'h4, bmode);
        chk("host_dma_h", 32'h1, hdma);
        chk("byte_dma_h", 32'h0, byte_dma);
        chk("mem_out_h", host_out, mem_out);
        chk("mem_oe_h", host_oe, mem_oe);
        chk("full_in_h", 16'h0, full_in);
        chk("host_in_lo", 16'h00c3, host_in & 16'h00ff);
        rd("mask_rst", PFMS_IRQ_MASK_OFS, 32'h0);
        rd("ctrl_rst", PFMS_SYS_CTRL_OFS, 32'h0);
        print_verdict();
    end
endmodule : testbench
